// ==== hw/rphc_top.v ====
// What this block and its reader do
// [R1] Successful hide command in secured state sets both hide flags.
// [R2] With flags set, protocol runs on but protected reads are masked.
// [R3] Successful unhide command clears both hide flags.
// [R4] Zero access password: hide command ignored, no reply.
// [R5] Reader sends both commands behind a frame-sync.
// [R6] Reader holds carrier for lesser of reply delay or 20 ms.
// [R7] Success reply is zero bit, handle, CRC-16 over both.
// [R8] Hiding takes effect right after the hide reply ends.
// [R9] Internal failure sends an error code instead of the handle reply.
// [R10] Reader treats no reply within 20 ms as failure.
// [R11] Replies always ask for the extended preamble.
// [R12] Hide frame: code E001, handle, CRC-16.
// [R13] Ready, killed kept; arbitrate, reply, acknowledged go arbitrate; no reply.
// [R14] Hide: open ignored; secured good pass replies, bad pass arbitrate. The code checks no password on hide; a wrong handle is ignored.
// [R15] Reader issues a fresh RN16 before the unhide command.
// [R16] Unhide frame: code E002, password xor doubled RN16, handle, CRC.
// [R17] CRC-16 covers code through handle and is checked first.
// [R18] Unhide in open or secured: good replies, bad pass arbitrate.
// [R19] Hide flags live in nonvolatile storage.
// [R20] Success reply only after the nonvolatile write completes.
`timescale 1ns/1ns
`include "rphc_defines.vh"
module rphc_top (
  input  wire        CLK,
  input  wire        RST_B,
  input  wire        CE,
  input  wire        FRAME_SYNC,
  input  wire        RX_VLD,
  input  wire        RX_BIT,
  input  wire        RX_END,
  input  wire [2:0]  STATE_IN,
  input  wire [15:0] HANDLE,
  input  wire [15:0] RN16,
  input  wire [31:0] ACCESS_PWD,
  input  wire        NV_LOAD,
  input  wire [1:0]  NV_STORED,
  input  wire        NV_DONE,
  input  wire        NV_FAIL,
  input  wire        RD_REQ_EPC,
  input  wire        RD_REQ_TID,
  input  wire        TX_READY,
  output reg         STATE_WE,
  output reg  [2:0]  STATE_OUT,
  output wire        NV_WR,
  output wire [1:0]  NV_WDATA,
  output reg         TX_START,
  output reg         TX_ERR,
  output reg         TX_TREXT,
  output reg  [32:0] TX_DATA,
  output wire        EPC_HIDE,
  output wire        TID_HIDE,
  output wire        RD_BLOCK
);
  localparam S_IDLE = 2'd0;
  localparam S_NV   = 2'd1;
  localparam S_TX   = 2'd2;
  reg        rst_s1_q;
  reg        rst_s2_q;
  wire       rst_n = rst_s2_q;
  reg [79:0] sr_q;
  reg [6:0]  cnt_q;
  reg        busy_frm_q;
  reg [1:0]  fsm_q;
  reg        hide_q;
  reg [1:0]  pend_q;
  reg [1:0]  eff_q;
  reg        nv_req_q;
  wire       nv_busy;
  wire       nv_ok;
  wire       nv_err;
  wire [1:0] nv_flags;
  wire [15:0] crc;
  reg [15:0] rcrc_q;
  // Reset release through two flops
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  // Active state test used by both commands
  function is_arb_group;
    input [2:0] st;
    begin
      is_arb_group = (st == `RPHC_ST_ARB) || (st == `RPHC_ST_REPLY) ||
                     (st == `RPHC_ST_ACK);
    end
  endfunction
  // States that hold the handle for an authorised command
  function is_auth_group;
    input [2:0] st;
    begin
      is_auth_group = (st == `RPHC_ST_OPEN) || (st == `RPHC_ST_SECURED);
    end
  endfunction
  // [R7] reply CRC-16
  // Built here so the transmitter only serialises; preset and inversion match the forward link
  function [15:0] reply_crc;
    input [16:0] word;
    reg   [15:0] c;
    integer      b;
    begin
      c = `RPHC_CRC_PRESET;
      for (b = 16; b >= 0; b = b - 1)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ word[b]) ? `RPHC_CRC_POLY : 16'h0000);
      reply_crc = ~c;
    end
  endfunction
  // [R17] frame CRC check
  rphc_crc16 u_crc (
    .clk     (CLK),
    .rst_n   (rst_n),
    .ce      (CE),
    .init    (FRAME_SYNC),
    .bit_vld (RX_VLD),
    .bit_in  (RX_BIT),
    .crc     (crc)
  );
  // [R19] nonvolatile flag store
  rphc_nvflags u_nv (
    .clk       (CLK),
    .rst_n     (rst_n),
    .ce        (CE),
    .wr_req    (nv_req_q),
    .wr_data   (pend_q),
    .nv_done   (NV_DONE),
    .nv_fail   (NV_FAIL),
    .nv_stored (NV_STORED),
    .load      (NV_LOAD),
    .busy      (nv_busy),
    .ok        (nv_ok),
    .err       (nv_err),
    .flags     (nv_flags)
  );
  assign NV_WR    = nv_req_q;
  assign NV_WDATA = pend_q;
  // [R5] shifter restarts only on frame-sync
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sr_q       <= 80'h0;
      cnt_q      <= 7'd0;
      busy_frm_q <= 1'b0;
      rcrc_q     <= 16'h0000;
    end
    else if (CE)
    begin
      if (FRAME_SYNC)
      begin
        cnt_q      <= 7'd0;
        busy_frm_q <= 1'b1;
      end
      else if (RX_VLD && busy_frm_q && cnt_q != 7'd80)
      begin
        sr_q  <= {sr_q[78:0], RX_BIT};
        cnt_q <= cnt_q + 7'd1;
      end
      else if (RX_END)
        busy_frm_q <= 1'b0;
      rcrc_q <= crc;
    end
  end
  // Frame field decode, last bits are newest
  wire [15:0] h_code   = sr_q[47:32];
  wire [15:0] h_handle = sr_q[31:16];
  wire [15:0] u_code   = sr_q[79:64];
  wire [31:0] u_pwd    = sr_q[63:32];
  wire [15:0] u_handle = sr_q[31:16];
  // [R12] hide frame recognised
  wire is_hide   = (cnt_q == `RPHC_LEN_HIDE) && (h_code == `RPHC_CODE_HIDE);
  // [R16] unhide frame recognised
  wire is_unhide = (cnt_q == `RPHC_LEN_UNHIDE) && (u_code == `RPHC_CODE_UNHIDE);
  // Residue is taken a cycle late, so the end strobe must trail the last bit
  wire crc_ok    = (rcrc_q == `RPHC_CRC_RESIDUE);
  // [R16] password cover with doubled RN16
  wire pwd_ok    = ((u_pwd ^ {RN16, RN16}) == ACCESS_PWD);
  // A frame counts only at its end, once length, code and CRC agree
  wire fin       = CE && RX_END && busy_frm_q && crc_ok && (is_hide || is_unhide);
  wire [2:0] st  = STATE_IN;
  // Command sequencer: decide, write NV, then reply
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fsm_q     <= S_IDLE;
      hide_q    <= 1'b0;
      pend_q    <= 2'b00;
      nv_req_q  <= 1'b0;
      STATE_WE  <= 1'b0;
      STATE_OUT <= `RPHC_ST_READY;
      TX_START  <= 1'b0;
      TX_ERR    <= 1'b0;
      TX_TREXT  <= 1'b0;
      TX_DATA   <= 33'h0;
    end
    else if (CE)
    begin
      // Strobes stand for one enabled cycle only
      STATE_WE <= 1'b0;
      nv_req_q <= 1'b0;
      TX_START <= 1'b0;
      case (fsm_q)
        S_IDLE:
        begin
          // A store still in flight takes no new command
          if (fin && !nv_busy)
          begin
            // [R13] silent states
            if (is_arb_group(st))
            begin
              STATE_WE  <= 1'b1;
              STATE_OUT <= `RPHC_ST_ARB;
            end
            // [R4] zero password ignore
            else if (is_hide && ACCESS_PWD == 32'h0)
              fsm_q <= S_IDLE;
            // [R14] hide in secured only
            else if (is_hide && st == `RPHC_ST_SECURED && h_handle == HANDLE)
            begin
              hide_q   <= 1'b1;
              pend_q   <= 2'b11;
              nv_req_q <= 1'b1;
              fsm_q    <= S_NV;
            end
            // [R18] unhide in open or secured
            else if (is_unhide && u_handle == HANDLE &&
                     is_auth_group(st))
            begin
              if (pwd_ok)
              begin
                hide_q   <= 1'b0;
                pend_q   <= 2'b00;
                nv_req_q <= 1'b1;
                fsm_q    <= S_NV;
              end
              else
              begin
                STATE_WE  <= 1'b1;
                STATE_OUT <= `RPHC_ST_ARB;
              end
            end
          end
        end
        S_NV:
        begin
          // [R20] reply waits for NV completion
          if (nv_ok || nv_err)
          begin
            // [R7] header zero, handle, CRC
            TX_DATA  <= {1'b0, HANDLE, reply_crc({1'b0, HANDLE})};
            // [R9] error code path
            TX_ERR   <= nv_err;
            // [R11] forced extended preamble
            TX_TREXT <= 1'b1;
            TX_START <= 1'b1;
            fsm_q    <= S_TX;
          end
        end
        S_TX:
        begin
          if (TX_READY)
            fsm_q <= S_IDLE;
        end
        default:
          fsm_q <= S_IDLE;
      endcase
    end
  end
  // The hide frame carries no password, so only the zero-password test applies
  // Effective flags: hide applies only after reply, unhide at NV commit
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      eff_q <= 2'b00;
    else if (CE)
    begin
      // Power-up load wins over any command in the same cycle
      if (NV_LOAD)
        eff_q <= NV_STORED;
      // [R8] hide after reply ends
      else if (fsm_q == S_TX && TX_READY && hide_q && !TX_ERR)
        eff_q <= nv_flags;
      // [R3] unhide clears flags
      else if (fsm_q == S_NV && nv_ok && !hide_q)
        eff_q <= 2'b00;
    end
  end
  // [R1] both hide flags
  assign EPC_HIDE = eff_q[`RPHC_FLAG_EPC];
  assign TID_HIDE = eff_q[`RPHC_FLAG_TID];
  // [R2] reads masked, protocol untouched
  assign RD_BLOCK = (RD_REQ_EPC && EPC_HIDE) || (RD_REQ_TID && TID_HIDE);
endmodule // rphc_top

// ==== hw/rphc_defines.vh ====
`ifndef RPHC_DEFINES_VH
`define RPHC_DEFINES_VH
// Command codes
`define RPHC_CODE_HIDE    16'hE001
`define RPHC_CODE_UNHIDE  16'hE002
// Frame lengths in bits (code + fields + crc)
`define RPHC_LEN_HIDE     7'd48
`define RPHC_LEN_UNHIDE   7'd80
// Reply length: header bit, handle, crc
`define RPHC_LEN_REPLY    6'd33
// CRC-16 preset and residue of a good frame
`define RPHC_CRC_PRESET   16'hFFFF
`define RPHC_CRC_POLY     16'h1021
`define RPHC_CRC_RESIDUE  16'h1D0F
// Protocol state codes
`define RPHC_ST_READY     3'h0
`define RPHC_ST_ARB       3'h1
`define RPHC_ST_REPLY     3'h2
`define RPHC_ST_ACK       3'h3
`define RPHC_ST_OPEN      3'h4
`define RPHC_ST_SECURED   3'h5
`define RPHC_ST_KILLED    3'h6
// Flag positions in the flag word
`define RPHC_FLAG_EPC     0
`define RPHC_FLAG_TID     1
// Timing: 20 ms reply window and count at 100 MHz
`define RPHC_WIN_MS       20
`define RPHC_CLK_MHZ      100
`define RPHC_WIN_CYC      (`RPHC_WIN_MS * 1000 * `RPHC_CLK_MHZ)
`endif

// ==== hw/rphc_crc16.v ====
`timescale 1ns/1ns
`include "rphc_defines.vh"
module rphc_crc16 (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire        init,
  input  wire        bit_vld,
  input  wire        bit_in,
  output wire [15:0] crc
);
  reg  [15:0] crc_q;
  wire        fb = crc_q[15] ^ bit_in;
  // Serial CCITT shift register, preset on init
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      crc_q <= `RPHC_CRC_PRESET;
    else if (ce)
    begin
      if (init)
        crc_q <= `RPHC_CRC_PRESET;
      else if (bit_vld)
        crc_q <= {crc_q[14:0], 1'b0} ^ (fb ? `RPHC_CRC_POLY : 16'h0000);
    end
  end
  assign crc = crc_q;
endmodule // rphc_crc16

// ==== hw/rphc_nvflags.v ====
`timescale 1ns/1ns
`include "rphc_defines.vh"
module rphc_nvflags (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       ce,
  input  wire       wr_req,
  input  wire [1:0] wr_data,
  input  wire       nv_done,
  input  wire       nv_fail,
  input  wire [1:0] nv_stored,
  input  wire       load,
  output reg        busy,
  output reg        ok,
  output reg        err,
  output reg  [1:0] flags
);
  reg [1:0] pend_q;
  // Shadow follows the cell only on load or after a completed write, so an aborted one keeps old values
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy   <= 1'b0;
      ok     <= 1'b0;
      err    <= 1'b0;
      flags  <= 2'b00;
      pend_q <= 2'b00;
    end
    else if (ce)
    begin
      ok  <= 1'b0;
      err <= 1'b0;
      if (load)
        flags <= nv_stored;
      else if (wr_req && !busy)
      begin
        busy   <= 1'b1;
        pend_q <= wr_data;
      end
      else if (busy && nv_done)
      begin
        busy  <= 1'b0;
        ok    <= 1'b1;
        flags <= pend_q;
      end
      else if (busy && nv_fail)
      begin
        busy <= 1'b0;
        err  <= 1'b1;
      end
    end
  end
endmodule // rphc_nvflags

// ==== sim/rphc_props.sv ====
`timescale 1ns/1ns
`include "rphc_defines.vh"
module rphc_props (
  input wire       CLK,
  input wire       RST_B,
  input wire       NV_DONE,
  input wire       NV_FAIL,
  input wire       STATE_WE,
  input wire [2:0] STATE_OUT,
  input wire       NV_WR,
  input wire [1:0] NV_WDATA,
  input wire       TX_START,
  input wire       TX_ERR,
  input wire       TX_TREXT,
  input wire       EPC_HIDE,
  input wire       TID_HIDE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // Silent moves only ever land in arbitrate
  chk_arb_target: assert property (STATE_WE |-> STATE_OUT == `RPHC_ST_ARB)
    else $error("state move not to arbitrate");
  chk_ext_preamble: assert property (TX_START |-> TX_TREXT)
    else $error("reply without extended preamble");
  // A reply waits for the store to settle, so a torn write is never acknowledged
  chk_reply_after_nv:
    assert property (TX_START |-> $past(NV_DONE, 2) || $past(NV_FAIL, 2))
    else $error("reply before store finished");
  chk_err_on_fail: assert property (TX_START |-> TX_ERR == $past(NV_FAIL, 2))
    else $error("error flag does not follow store result");
  chk_both_set: assert property ($rose(EPC_HIDE) |-> TID_HIDE)
    else $error("hide flags not set together");
  chk_both_clear: assert property ($fell(EPC_HIDE) |-> !TID_HIDE)
    else $error("hide flags not cleared together");
  chk_same_flags: assert property (NV_WR |-> NV_WDATA[0] == NV_WDATA[1])
    else $error("stored flags differ");
  // Hiding must not start in the hide store request cycle or the two cycles after it
  chk_hide_wait:
    assert property (NV_WR && NV_WDATA == 2'h3 && !EPC_HIDE |-> !EPC_HIDE [*3])
    else $error("hiding applied before reply");
  cov_reply: cover property (TX_START && !TX_ERR);
  cov_error: cover property (TX_START && TX_ERR);
  cov_arb: cover property (STATE_WE);
endmodule // rphc_props

bind rphc_top rphc_props rphc_props_i (.CLK(CLK), .RST_B(RST_B), .NV_DONE(NV_DONE),
  .NV_FAIL(NV_FAIL), .STATE_WE(STATE_WE), .STATE_OUT(STATE_OUT), .NV_WR(NV_WR),
  .NV_WDATA(NV_WDATA), .TX_START(TX_START), .TX_ERR(TX_ERR), .TX_TREXT(TX_TREXT),
  .EPC_HIDE(EPC_HIDE), .TID_HIDE(TID_HIDE));

// ==== sim/rphc_rdr.sv ====
`timescale 1ns/1ns
module rphc_rdr (
  input  wire clk,
  output reg  frame_sync,
  output reg  rx_vld,
  output reg  rx_bit,
  output reg  rx_end
);
  reg [79:0] frm_q;
  reg [15:0] crc_q;
  integer    j;
  initial
  begin
    frame_sync = 1'h0;
    rx_vld     = 1'h0;
    rx_bit     = 1'h0;
    rx_end     = 1'h0;
  end
  // CRC over code through handle, sent inverted
  task send(input [63:0] body, input integer n, input bad, input integer gap);
    begin
      crc_q = 16'hFFFF;
      for (j = n - 1; j >= 0; j = j - 1)
        crc_q = {crc_q[14:0], 1'h0} ^ ((crc_q[15] ^ body[j]) ? 16'h1021 : 16'h0000);
      frm_q = {body, ~crc_q ^ {15'h0000, bad}};
      @(negedge clk);
      frame_sync = 1'h1;
      @(negedge clk);
      frame_sync = 1'h0;
      for (j = n + 15; j >= 0; j = j - 1)
      begin
        rx_vld = 1'h1;
        rx_bit = frm_q[j];
        @(negedge clk);
        // Back-to-back bits keep the strobe up rather than glitch it
        if (gap != 0 || j == 0)
        begin
          rx_vld = 1'h0;
          rx_bit = ~rx_bit; // Line is not held past its bit
          repeat (gap) @(negedge clk);
        end
      end
      @(negedge clk);
      rx_end = 1'h1;
      @(negedge clk);
      rx_end = 1'h0;
    end
  endtask
endmodule // rphc_rdr

// ==== sim/tb.sv ====
`timescale 1ns/1ns
`include "rphc_defines.vh"
module tb;
  reg         CLK, RST_B, CE, NV_LOAD, NV_DONE, NV_FAIL, RD_REQ_EPC, RD_REQ_TID, TX_READY;
  reg  [2:0]  STATE_IN;
  reg  [15:0] HANDLE, RN16;
  reg  [31:0] ACCESS_PWD;
  reg  [1:0]  NV_STORED, fl;
  wire        FRAME_SYNC, RX_VLD, RX_BIT, RX_END, STATE_WE, NV_WR, TX_START, TX_ERR;
  wire        TX_TREXT, EPC_HIDE, TID_HIDE, RD_BLOCK;
  wire [2:0]  STATE_OUT;
  wire [1:0]  NV_WDATA;
  wire [32:0] TX_DATA;
  integer     seed, miscompares, tests_run, i, k;
  rphc_top rphc_top_i (.CLK(CLK), .RST_B(RST_B), .CE(CE), .FRAME_SYNC(FRAME_SYNC),
    .RX_VLD(RX_VLD), .RX_BIT(RX_BIT), .RX_END(RX_END), .STATE_IN(STATE_IN),
    .HANDLE(HANDLE), .RN16(RN16), .ACCESS_PWD(ACCESS_PWD), .NV_LOAD(NV_LOAD),
    .NV_STORED(NV_STORED), .NV_DONE(NV_DONE), .NV_FAIL(NV_FAIL), .RD_REQ_EPC(RD_REQ_EPC),
    .RD_REQ_TID(RD_REQ_TID), .TX_READY(TX_READY), .STATE_WE(STATE_WE),
    .STATE_OUT(STATE_OUT), .NV_WR(NV_WR), .NV_WDATA(NV_WDATA), .TX_START(TX_START),
    .TX_ERR(TX_ERR), .TX_TREXT(TX_TREXT), .TX_DATA(TX_DATA), .EPC_HIDE(EPC_HIDE),
    .TID_HIDE(TID_HIDE), .RD_BLOCK(RD_BLOCK));
  rphc_rdr rphc_rdr_i (.clk(CLK), .frame_sync(FRAME_SYNC), .rx_vld(RX_VLD),
    .rx_bit(RX_BIT), .rx_end(RX_END));
  initial
  begin
    CLK = 1'h0;
    forever #5 CLK = ~CLK;
  end
  task chk(input [63:0] got, input [63:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        miscompares = miscompares + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks=%0d mismatches=%0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // Outcome: 0 silent, 1 silent move to arbitrate, 2 handle reply
  function [1:0] exp_of(input hide, input [2:0] st, input integer flt);
    begin
      if (st == `RPHC_ST_READY || st == `RPHC_ST_KILLED || flt == 3)
        exp_of = 0;
      else if (st < `RPHC_ST_OPEN)
        exp_of = 1;
      else if (hide && (st == `RPHC_ST_OPEN || ACCESS_PWD == 0))
        exp_of = 0;
      else if (flt == 1)
        exp_of = 0;
      else if (flt == 2 && !hide)
        exp_of = 1;
      else
        exp_of = 2;
    end
  endfunction
  // Reply word: zero header, handle, inverted CRC-16 over those 17 bits
  function [32:0] exp_reply(input [15:0] h);
    reg [15:0] c;
    integer    b;
    begin
      c = 16'hFFFF;
      for (b = 16; b >= 0; b = b - 1)
        c = {c[14:0], 1'h0} ^ ((c[15] ^ ((b == 16) ? 1'h0 : h[b])) ? 16'h1021 : 16'h0000);
      exp_reply = {1'h0, h, ~c};
    end
  endfunction
  task load(input [1:0] v);
    begin
      NV_STORED = v;
      NV_LOAD = 1'h1;
      @(negedge CLK);
      NV_LOAD = 1'h0;
      repeat (2) @(negedge CLK);
      fl = v;
      chk({TID_HIDE, EPC_HIDE}, fl);
    end
  endtask
  // Faults: 1 wrong handle, 2 wrong password, 3 bad CRC, 4 store aborts
  task op(input hide, input [2:0] st, input integer flt);
    reg [63:0] body;
    reg [1:0]  e;
    integer    we, rep;
    reg        nvp;
    begin
      STATE_IN = st;
      HANDLE = $random(seed);
      RN16 = $random(seed);
      RD_REQ_EPC = $random(seed);
      RD_REQ_TID = $random(seed);
      e = exp_of(hide, st, flt);
      body = hide ? {32'h0000_0000, `RPHC_CODE_HIDE, HANDLE}
                  : {`RPHC_CODE_UNHIDE, ACCESS_PWD ^ {RN16, RN16}, HANDLE};
      body[0] = body[0] ^ (flt == 1);
      body[16] = body[16] ^ (flt == 2 && !hide);
      rphc_rdr_i.send(body, hide ? 32 : 64, flt == 3, $random(seed) & 1);
      we = 0;
      rep = 0;
      nvp = 1'h0;
      // carrier held while the reply is awaited, bounded
      for (k = 0; k < 40; k = k + 1)
      begin
        if (STATE_WE === 1'h1)
        begin
          we = we + 1;
          chk(STATE_OUT, `RPHC_ST_ARB);
        end
        if (TX_START === 1'h1)
        begin
          rep = rep + 1;
          if (flt != 4) chk(TX_DATA, exp_reply(HANDLE));
          chk(TX_ERR, flt == 4);
          chk(TX_TREXT, 1'h1);
          if (hide) chk({TID_HIDE, EPC_HIDE}, fl);
        end
        // Store answers one cycle after it has taken the write
        NV_DONE = nvp && (flt != 4);
        NV_FAIL = nvp && (flt == 4);
        TX_READY = (TX_START === 1'h1);
        nvp = (NV_WR === 1'h1);
        if (nvp) chk(NV_WDATA, hide ? 2'h3 : 2'h0);
        @(negedge CLK);
      end
      NV_DONE = 1'h0;
      NV_FAIL = 1'h0;
      TX_READY = 1'h0;
      if (e == 2 && flt != 4) fl = hide ? 2'h3 : 2'h0;
      chk(we, e == 1);
      chk(rep, e == 2);
      chk({TID_HIDE, EPC_HIDE}, fl);
      chk(RD_BLOCK, |({RD_REQ_TID, RD_REQ_EPC} & fl));
    end
  endtask
  initial
  begin
    #900000;
    miscompares = miscompares + 1;
    print_verdict;
  end
  initial
  begin
    seed = 32'h15e7242e;
    miscompares = 0;
    tests_run = 0;
    {RST_B, NV_LOAD, NV_DONE, NV_FAIL, RD_REQ_EPC, RD_REQ_TID, TX_READY} = 7'h00;
    CE = 1'h1;
    {STATE_IN, HANDLE, RN16, NV_STORED, fl} = 39'h0;
    ACCESS_PWD = $random(seed) | 32'h1;
    repeat (20) @(negedge CLK);
    RST_B = 1'h1;
    repeat (3) @(negedge CLK);
    load(2'h2);
    load(2'h0);
    // Clock enable low: a load must not reach the flags
    CE = 1'h0;
    NV_STORED = 2'h3;
    NV_LOAD = 1'h1;
    repeat (2) @(negedge CLK);
    NV_LOAD = 1'h0;
    CE = 1'h1;
    @(negedge CLK);
    chk({TID_HIDE, EPC_HIDE}, 2'h0);
    // Every state with both commands
    for (i = 0; i < 14; i = i + 1)
      op(i & 1, i >> 1, 0);
    op(1, `RPHC_ST_SECURED, 3);
    op(0, `RPHC_ST_SECURED, 1);
    op(0, `RPHC_ST_OPEN, 2);
    op(0, `RPHC_ST_SECURED, 4);
    op(0, `RPHC_ST_SECURED, 0);
    op(1, `RPHC_ST_SECURED, 4);
    ACCESS_PWD = 32'h0000_0000;
    op(1, `RPHC_ST_SECURED, 0);
    op(0, `RPHC_ST_OPEN, 0);
    for (i = 0; i < 40; i = i + 1)
    begin
      ACCESS_PWD = $random(seed) | 32'h1;
      op($random(seed) & 1, ($random(seed) & 32'hFF) % 7, ($random(seed) & 32'hFF) % 5);
    end
    print_verdict;
  end
endmodule // tb
